//--- src/slave_fifo_device.sv
// Device end: endpoint FIFOs behind the asynchronous slave port.
`timescale 1ns/1ps
`include "fifo_port_params.svh"
module slave_fifo_device #(
	parameter int DATA_WIDTH = `DATA_WIDTH,
	parameter int ADDR_WIDTH = `ADDR_WIDTH,
	parameter int DEPTH      = `FIFO_DEPTH
) (
	input  wire logic                   clock,
	input  wire logic                   arst_n,
	fifo_port_if.device                 port,
	output logic [(1<<ADDR_WIDTH)-1:0]  fifo_empty,
	output logic [(1<<ADDR_WIDTH)-1:0]  fifo_full,
	output logic                        packet_commit,
	output logic [ADDR_WIDTH-1:0]       packet_fifo,
	output logic [$clog2(DEPTH):0]      packet_length
);
	localparam int NFIFO      = 1 << ADDR_WIDTH;
	localparam int PW         = $clog2(DEPTH);
	localparam int PULSE      = `STROBE_PULSE_CYCLES;
	localparam int FLAG_DELAY = `FLAG_DELAY_CYCLES;
	// A power-of-two depth lets the pointers wrap without extra compare logic.
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : bad_depth
		$error("FIFO depth must be a power of two of at least two.");
	end
	if (DATA_WIDTH != `DATA_WIDTH || ADDR_WIDTH != `ADDR_WIDTH) begin : bad_width
		$error("Port widths must match the pin bundle.");
	end
	if (PULSE < 1 || PULSE > 254 || FLAG_DELAY < 1) begin : bad_timing
		$error("Strobe and flag counts must be at least one cycle.");
	end

	logic [4+ADDR_WIDTH:0]  sync_out;
	logic                   cs;
	logic                   oe;
	logic                   rd;
	logic                   wr;
	logic                   pe;
	logic [ADDR_WIDTH-1:0]  addr;
	logic [DATA_WIDTH-1:0]  din;
	pin_sync #(.WIDTH(5 + ADDR_WIDTH + DATA_WIDTH), .RESET_VALUE({5'h1F, {(ADDR_WIDTH + DATA_WIDTH){1'b0}}})) sync (
		.clock (clock),
		.arst_n(arst_n),
		.pin   ({port.slave_chip_select_n, port.slave_output_enable_n, port.slave_read_strobe_n,
			port.slave_write_strobe_n, port.packet_end_strobe_n, port.fifo_select_address, port.data_bus}),
		.level ({sync_out, din})
	);
	logic                   cs_n;
	logic                   oe_n;
	logic                   rd_n;
	logic                   wr_n;
	logic                   pe_n;
	assign {cs_n, oe_n, rd_n, wr_n, pe_n, addr} = sync_out;
	assign cs = !cs_n;
	assign oe = !oe_n;
	assign rd = !rd_n;
	assign wr = !wr_n;
	assign pe = !pe_n;

	logic                   rd_q;
	logic                   wr_q;
	logic                   pe_q;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rd_q <= 1'b0;
			wr_q <= 1'b0;
			pe_q <= 1'b0;
		end else begin
			rd_q <= rd && cs;
			wr_q <= wr && cs;
			pe_q <= pe && cs;
		end
	end

	// A packet end counts only once the write strobe has rested a full pulse, so no late write joins it.
	logic [7:0]             wr_rest;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			wr_rest <= 8'hFF;
		end else if (wr && cs) begin
			wr_rest <= 8'h00;
		end else if (wr_rest != 8'hFF) begin
			wr_rest <= wr_rest + 8'h01;
		end
	end

	logic                   read_edge;
	logic                   write_release;
	logic                   commit_edge;
	assign read_edge     = rd && cs && !rd_q;
	assign write_release = wr_q && !(wr && cs);
	assign commit_edge   = pe && cs && !pe_q && !wr && wr_rest >= 8'(PULSE);

	logic [DATA_WIDTH-1:0] mem [NFIFO][DEPTH];
	logic [PW:0] rptr [NFIFO];
	logic [PW:0] wptr [NFIFO];
	logic [PW:0] cptr [NFIFO];
	logic [ADDR_WIDTH-1:0] wr_addr;
	logic [DATA_WIDTH-1:0] wr_data;

	// Address and data are latched while the strobe is low, since they may change right after release.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			wr_addr <= '0;
			wr_data <= '0;
		end else if (wr && cs) begin
			wr_addr <= addr;
			wr_data <= din;
		end
	end

	logic [DATA_WIDTH-1:0]  held;
	logic [NFIFO-1:0]       readable;
	genvar f;
	generate
		for (f = 0; f < NFIFO; f++) begin : ch
			logic [PW:0]            next_wptr;
			logic [PW:0]            next_rptr;
			logic [PW:0]            fill;
			logic                   accept;
			logic [FLAG_DELAY-1:0]  empty_line;
			logic [FLAG_DELAY-1:0]  full_line;
			assign next_wptr   = wptr[f] + 1'b1;
			assign next_rptr   = rptr[f] + 1'b1;
			assign fill        = wptr[f] - rptr[f];
			// A write to a full FIFO is dropped rather than overwriting words not yet read.
			assign accept      = write_release && wr_addr == f && fill != DEPTH[PW:0];
			assign readable[f] = rptr[f] != cptr[f];
			always_ff @(posedge clock) begin
				if (accept)
					mem[f][wptr[f][PW-1:0]] <= wr_data;
			end
			always_ff @(posedge clock or negedge arst_n) begin
				if (!arst_n) begin
					wptr[f] <= '0;
				end else if (accept) begin
					wptr[f] <= next_wptr;
				end
			end
			always_ff @(posedge clock or negedge arst_n) begin
				if (!arst_n) begin
					cptr[f] <= '0;
				end else if (commit_edge && addr == f) begin
					cptr[f] <= wptr[f];
				end
			end
			// Only committed words are readable, so a partial packet stays hidden until packet end.
			always_ff @(posedge clock or negedge arst_n) begin
				if (!arst_n) begin
					rptr[f] <= '0;
				end else if (read_edge && addr == f && readable[f]) begin
					rptr[f] <= next_rptr;
				end
			end
			// Flags trail the pointers through a short line, so they settle a fixed time after a write release, packet end or read edge.
			always_ff @(posedge clock or negedge arst_n) begin
				if (!arst_n) begin
					empty_line <= '1;
					full_line  <= '0;
				end else begin
					empty_line <= FLAG_DELAY'({empty_line, !readable[f]});
					full_line  <= FLAG_DELAY'({full_line, fill == DEPTH[PW:0]});
				end
			end
			assign fifo_empty[f] = empty_line[FLAG_DELAY-1];
			assign fifo_full[f]  = full_line[FLAG_DELAY-1];
		end
	endgenerate

	// The output word changes only on a read edge; otherwise the prior read stays on the bus.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			held <= '0;
		end else if (read_edge && readable[addr]) begin
			held <= mem[addr][rptr[addr][PW-1:0]];
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			port.dev_data_out <= '0;
		end else begin
			port.dev_data_out <= held;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			port.dev_data_oe <= 1'b0;
		end else begin
			port.dev_data_oe <= oe;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			packet_commit <= 1'b0;
		end else begin
			packet_commit <= commit_edge;
		end
	end

	// The packet description stands until the next commit, so the host side may read it at leisure.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			packet_fifo   <= '0;
			packet_length <= '0;
		end else if (commit_edge) begin
			packet_fifo   <= addr;
			packet_length <= wptr[addr] - cptr[addr];
		end
	end
endmodule

//--- include/fifo_port_params.svh
// Timing counts and widths for the asynchronous slave FIFO port.
// Behaviour
// - Master sets address and select before reading.
// - Output enable makes device drive data.
// - Before strobe, bus shows prior read data.
// - Read starts only with select and strobe.
// - Read strobe edge presents updated FIFO word.
// - Data appears only while output enable asserted.
// - Master may tie read strobe to enable.
// - Burst read drives word, then advances pointer.
// - Master sets address, select before write strobe.
// - Master sets data before write strobe release.
// - Write strobe release stores word, post-increments.
// - Flags update fixed delay after write release; empty flag clears only after packet end.
// - Packet end commits partial buffer as packet.
// - Never write strobe and packet end together.
// - Packet end only after write inactive width.
// - Address stays stable during packet end.
`ifndef FIFO_PORT_PARAMS_SVH
`define FIFO_PORT_PARAMS_SVH
`define CLOCK_PERIOD_NS 20
`define STROBE_PULSE_NS 50
`define STROBE_PULSE_CYCLES ((`STROBE_PULSE_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define FLAG_DELAY_NS 20
`define FLAG_DELAY_CYCLES ((`FLAG_DELAY_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define DATA_WIDTH 8
`define ADDR_WIDTH 2
`define FIFO_DEPTH 16
`endif

//--- include/fifo_port_pkg.sv
// Types used by the master end of the slave FIFO port.
package fifo_port_pkg;
	typedef enum logic [2:0] {
		idle,
		setup,
		strobe_on,
		strobe_off,
		commit_on,
		commit_off
	} master_state_t;
endpackage

//--- include/fifo_port_if.sv
// Pin bundle between the external master and the slave FIFO port.
`timescale 1ns/1ps
`include "fifo_port_params.svh"
interface fifo_port_if;
	logic                      slave_chip_select_n;
	logic                      slave_output_enable_n;
	logic                      slave_read_strobe_n;
	logic                      slave_write_strobe_n;
	logic                      packet_end_strobe_n;
	logic [`ADDR_WIDTH-1:0]    fifo_select_address;
	logic [`DATA_WIDTH-1:0]    dev_data_out;
	logic                      dev_data_oe;
	logic [`DATA_WIDTH-1:0]    mst_data_out;
	logic                      mst_data_oe;
	logic [`DATA_WIDTH-1:0]    data_bus;
	assign data_bus = dev_data_oe ? dev_data_out : (mst_data_oe ? mst_data_out : '0);
	modport device (
		input  slave_chip_select_n,
		input  slave_output_enable_n,
		input  slave_read_strobe_n,
		input  slave_write_strobe_n,
		input  packet_end_strobe_n,
		input  fifo_select_address,
		input  data_bus,
		output dev_data_out,
		output dev_data_oe
	);
	modport master (
		output slave_chip_select_n,
		output slave_output_enable_n,
		output slave_read_strobe_n,
		output slave_write_strobe_n,
		output packet_end_strobe_n,
		output fifo_select_address,
		input  data_bus,
		output mst_data_out,
		output mst_data_oe
	);
endinterface

//--- src/pin_sync.sv
// Two-flip-flop synchroniser for a group of pin levels.
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input  wire logic             clock,
	input  wire logic             arst_n,
	input  wire logic [WIDTH-1:0] pin,
	output logic      [WIDTH-1:0] level
);
	logic [WIDTH-1:0] stage;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			stage <= RESET_VALUE;
			level <= RESET_VALUE;
		end else begin
			stage <= pin;
			level <= stage;
		end
	end
endmodule

//--- src/slave_fifo_master.sv
// Master end: drives the asynchronous strobes for single reads, writes and packet end.
`timescale 1ns/1ps
`include "fifo_port_params.svh"
module slave_fifo_master #(
	parameter int DATA_WIDTH = `DATA_WIDTH,
	parameter int ADDR_WIDTH = `ADDR_WIDTH
) (
	input  wire logic                  clock,
	input  wire logic                  arst_n,
	fifo_port_if.master                port,
	input  wire logic                  req_valid,
	input  wire logic [1:0]            req_kind,
	input  wire logic [ADDR_WIDTH-1:0] req_addr,
	input  wire logic [DATA_WIDTH-1:0] req_data,
	output logic                       req_ready,
	output logic                       rsp_valid,
	output logic [DATA_WIDTH-1:0]      rsp_data
);
	localparam int PULSE = `STROBE_PULSE_CYCLES;
	if (DATA_WIDTH != `DATA_WIDTH || ADDR_WIDTH != `ADDR_WIDTH || PULSE < 1 || PULSE > 250) begin : bad_geometry
		$error("Unsupported master geometry.");
	end
	fifo_port_pkg::master_state_t state;
	logic [1:0] kind;
	logic [7:0] count;
	logic [DATA_WIDTH-1:0] bus_sync;
	pin_sync #(.WIDTH(DATA_WIDTH)) sync (
		.clock (clock),
		.arst_n(arst_n),
		.pin   (port.data_bus),
		.level (bus_sync)
	);
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state                      <= fifo_port_pkg::idle;
			kind                       <= 2'h0;
			count                      <= 8'h00;
			req_ready                  <= 1'b1;
			rsp_valid                  <= 1'b0;
			rsp_data                   <= '0;
			port.slave_chip_select_n   <= 1'b1;
			port.slave_output_enable_n <= 1'b1;
			port.slave_read_strobe_n   <= 1'b1;
			port.slave_write_strobe_n  <= 1'b1;
			port.packet_end_strobe_n   <= 1'b1;
			port.fifo_select_address   <= '0;
			port.mst_data_out          <= '0;
			port.mst_data_oe           <= 1'b0;
		end else begin
			rsp_valid <= 1'b0;
			count     <= count + 8'h01;
			case (state)
				fifo_port_pkg::idle: begin
					if (req_valid && req_ready) begin
						kind                     <= req_kind;
						req_ready                <= 1'b0;
						port.fifo_select_address <= req_addr;
						port.slave_chip_select_n <= 1'b0;
						port.mst_data_out        <= req_data;
						port.mst_data_oe         <= req_kind == 2'h1;
						count                    <= 8'h00;
						state                    <= fifo_port_pkg::setup;
					end
				end
				fifo_port_pkg::setup: begin
					count <= 8'h00;
					if (kind == 2'h0) begin
						port.slave_output_enable_n <= 1'b0;
						port.slave_read_strobe_n   <= 1'b0;
						state                      <= fifo_port_pkg::strobe_on;
					end else if (kind == 2'h1) begin
						port.slave_write_strobe_n <= 1'b0;
						state                     <= fifo_port_pkg::strobe_on;
					end else begin
						port.packet_end_strobe_n <= 1'b0;
						state                    <= fifo_port_pkg::commit_on;
					end
				end
				fifo_port_pkg::strobe_on: begin
					// The pulse covers both the device synchroniser and data settling.
					if (count >= 8'(PULSE + 4)) begin
						count                      <= 8'h00;
						rsp_data                   <= bus_sync;
						rsp_valid                  <= kind == 2'h0;
						port.slave_read_strobe_n   <= 1'b1;
						port.slave_output_enable_n <= 1'b1;
						port.slave_write_strobe_n  <= 1'b1;
						state                      <= fifo_port_pkg::strobe_off;
					end
				end
				fifo_port_pkg::commit_on: begin
					if (count >= 8'(PULSE + 4)) begin
						count                    <= 8'h00;
						port.packet_end_strobe_n <= 1'b1;
						state                    <= fifo_port_pkg::commit_off;
					end
				end
				fifo_port_pkg::strobe_off, fifo_port_pkg::commit_off: begin
					// Address and select hold through the inactive width so the next strobe is spaced.
					if (count >= 8'(PULSE + 4)) begin
						port.slave_chip_select_n <= 1'b1;
						port.mst_data_oe         <= 1'b0;
						req_ready                <= 1'b1;
						state                    <= fifo_port_pkg::idle;
					end
				end
				default: state <= fifo_port_pkg::idle;
			endcase
		end
	end
endmodule

//--- testbench/async_slave_fifo_port_props.sv
// Interface-level assertions for the asynchronous slave FIFO port.
`timescale 1ns/1ps
`include "fifo_port_params.svh"
module async_slave_fifo_port_props (
	input wire logic                   clock,
	input wire logic                   arst_n,
	input wire logic                   slave_chip_select_n,
	input wire logic                   slave_output_enable_n,
	input wire logic                   slave_read_strobe_n,
	input wire logic                   slave_write_strobe_n,
	input wire logic                   packet_end_strobe_n,
	input wire logic [`ADDR_WIDTH-1:0] fifo_select_address,
	input wire logic [`DATA_WIDTH-1:0] dev_data_out,
	input wire logic                   dev_data_oe,
	input wire logic [`DATA_WIDTH-1:0] mst_data_out,
	input wire logic                   mst_data_oe
);
	logic [3:0] rd_age;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);
	// Saturating age of the last selected read strobe.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			rd_age <= 4'hF;
		else if (!slave_read_strobe_n && !slave_chip_select_n)
			rd_age <= 4'h0;
		else if (rd_age != 4'hF)
			rd_age <= rd_age + 4'h1;
	end
	sequence s_read_start;
		!slave_chip_select_n && $fell(slave_read_strobe_n);
	endsequence
	sequence s_write_end;
		$rose(slave_write_strobe_n);
	endsequence
	a_read_needs_select: assert property ($fell(slave_read_strobe_n) |-> !slave_chip_select_n)
		else $error("read strobe without select");
	a_write_needs_select: assert property ($fell(slave_write_strobe_n) |-> !slave_chip_select_n)
		else $error("write strobe without select");
	a_read_setup: assert property ($fell(slave_read_strobe_n) |-> !$past(slave_chip_select_n)
		&& $stable(fifo_select_address)) else $error("read without address setup");
	a_write_data_setup: assert property (s_write_end |-> $past(mst_data_oe, 1) && $past(mst_data_oe, 2))
		else $error("write data not set up");
	a_no_strobe_overlap: assert property (slave_write_strobe_n || packet_end_strobe_n)
		else $error("write and packet end overlap");
	a_end_after_gap: assert property ($fell(packet_end_strobe_n) |-> $past(slave_write_strobe_n, 1)
		&& $past(slave_write_strobe_n, 3)) else $error("packet end too soon");
	a_end_addr_hold: assert property (!packet_end_strobe_n && !$past(packet_end_strobe_n)
		|-> $stable(fifo_select_address)) else $error("address moved in packet end");
	a_enable_drives: assert property ($fell(slave_output_enable_n) |-> ##[1:4] dev_data_oe)
		else $error("bus not driven");
	a_enable_source: assert property ($rose(dev_data_oe) |-> !$past(slave_output_enable_n, 2))
		else $error("bus driven without enable");
	a_release_bus: assert property (slave_output_enable_n [*4] |-> !dev_data_oe)
		else $error("bus not released");
	a_prior_word: assert property (s_read_start |-> $stable(dev_data_out) [*2])
		else $error("word changed before read");
	a_update_on_read: assert property ($changed(dev_data_out) |-> rd_age < 4'h8)
		else $error("word changed without read");
endmodule

//--- testbench/async_slave_fifo_port_bench.sv
// Self-checking bench joining master and device ends of the slave FIFO port.
`timescale 1ns/1ps
`include "fifo_port_params.svh"
module async_slave_fifo_port_bench;
	typedef struct packed {logic [1:0] kind; logic [1:0] addr; logic [7:0] data; logic [7:0] want;} row_t;
	logic       clock, arst_n, req_valid, req_ready, rsp_valid, packet_commit, got;
	logic [1:0] req_kind, req_addr, packet_fifo, last_fifo;
	logic [7:0] req_data, rsp_data, last_rsp;
	logic [3:0] fifo_empty, fifo_full;
	logic [4:0] packet_length, last_len;
	int         num_errors, compares, i;
	// Kinds: 0 read, 1 write, 2 and 3 packet end; want is read data or packet length.
	row_t rows [8] = '{'{2'h1, 2'h0, 8'hA5, 8'h00}, '{2'h1, 2'h0, 8'h5A, 8'h00}, '{2'h2, 2'h0, 8'h00, 8'h02},
		'{2'h1, 2'h1, 8'h3C, 8'h00}, '{2'h3, 2'h1, 8'h00, 8'h01}, '{2'h0, 2'h0, 8'h00, 8'hA5},
		'{2'h0, 2'h1, 8'h00, 8'h3C}, '{2'h0, 2'h0, 8'h00, 8'h5A}};
	fifo_port_if bus ();
	slave_fifo_device u_slave_fifo_device (.clock(clock), .arst_n(arst_n), .port(bus.device),
		.fifo_empty(fifo_empty), .fifo_full(fifo_full), .packet_commit(packet_commit),
		.packet_fifo(packet_fifo), .packet_length(packet_length));
	slave_fifo_master u_slave_fifo_master (.clock(clock), .arst_n(arst_n), .port(bus.master),
		.req_valid(req_valid), .req_kind(req_kind), .req_addr(req_addr), .req_data(req_data),
		.req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
	async_slave_fifo_port_props chk (.clock(clock), .arst_n(arst_n),
		.slave_chip_select_n(bus.slave_chip_select_n), .slave_output_enable_n(bus.slave_output_enable_n),
		.slave_read_strobe_n(bus.slave_read_strobe_n), .slave_write_strobe_n(bus.slave_write_strobe_n),
		.packet_end_strobe_n(bus.packet_end_strobe_n), .fifo_select_address(bus.fifo_select_address),
		.dev_data_out(bus.dev_data_out), .dev_data_oe(bus.dev_data_oe),
		.mst_data_out(bus.mst_data_out), .mst_data_oe(bus.mst_data_oe));
	always #10 clock = ~clock;
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
		compares++;
		if (seen !== want) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic tally_and_finish;
		$display("Counts: %0d compares, %0d mismatches", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Watching six idle cycles past ready catches pulses that trail the strobes through the synchroniser.
	task automatic do_req(input logic [1:0] k, input logic [1:0] a, input logic [7:0] d);
		int n;
		int idle;
		got = 1'b0;
		idle = 0;
		req_valid = 1'b1;
		req_kind = k;
		req_addr = a;
		req_data = d;
		for (n = 0; n < 100 && req_ready !== 1'b1; n++)
			@(negedge clock);
		if (n == 100) begin
			check("ready timeout", 8'h00, 8'h01);
			tally_and_finish();
		end
		@(negedge clock);
		req_valid = 1'b0;
		for (n = 0; n < 100 && idle < 6; n++) begin
			@(negedge clock);
			if (rsp_valid === 1'b1)
				last_rsp = rsp_data;
			if (packet_commit === 1'b1) begin
				got = 1'b1;
				last_len = packet_length;
				last_fifo = packet_fifo;
			end
			if (n > 2 && req_ready === 1'b1)
				idle++;
		end
		if (n == 100) begin
			check("request timeout", 8'h00, 8'h01);
			tally_and_finish();
		end
	endtask
	task automatic reset_check;
		check("empty flags", {4'h0, fifo_empty}, 8'h0F);
		check("full flags", {4'h0, fifo_full}, 8'h00);
		check("device drive", {7'h0, bus.dev_data_oe}, 8'h00);
	endtask
	initial begin
		clock = 1'b0;
		arst_n = 1'b0;
		req_valid = 1'b0;
		req_kind = 2'h0;
		req_addr = 2'h0;
		req_data = 8'h00;
		num_errors = 0;
		compares = 0;
		repeat (6) @(negedge clock);
		reset_check();
		arst_n = 1'b1;
		@(negedge clock);
		$display("Reset test done");
		foreach (rows[r]) begin
			do_req(rows[r].kind, rows[r].addr, rows[r].data);
			if (rows[r].kind == 2'h0)
				check("read word", last_rsp, rows[r].want);
			if (rows[r].kind[1]) begin
				check("commit seen", {7'h0, got}, 8'h01);
				check("packet length", {3'h0, last_len}, rows[r].want);
				check("packet fifo", {6'h0, last_fifo}, {6'h0, rows[r].addr});
			end
		end
		$display("Table test done");
		// Written but uncommitted words stay invisible to the read side.
		do_req(2'h1, 2'h2, 8'h77);
		check("uncommitted empty", {7'h0, fifo_empty[2]}, 8'h01);
		for (i = 1; i < 16; i++)
			do_req(2'h1, 2'h2, 8'h80 + 8'(i));
		check("full flag", {7'h0, fifo_full[2]}, 8'h01);
		do_req(2'h1, 2'h2, 8'hEE);
		do_req(2'h2, 2'h2, 8'h00);
		check("full packet length", {3'h0, last_len}, 8'h10);
		for (i = 0; i < 16; i++) begin
			do_req(2'h0, 2'h2, 8'h00);
			check("burst word", last_rsp, (i == 0) ? 8'h77 : 8'h80 + 8'(i));
		end
		check("drained empty", {7'h0, fifo_empty[2]}, 8'h01);
		$display("Fill and drain test done");
		do_req(2'h0, 2'h3, 8'h00);
		check("empty read word", last_rsp, 8'h8F);
		$display("Empty read test done");
		arst_n = 1'b0;
		@(negedge clock);
		reset_check();
		arst_n = 1'b1;
		repeat (3) @(negedge clock);
		last_rsp = 8'hFF;
		do_req(2'h0, 2'h0, 8'h00);
		check("read after reset", last_rsp, 8'h00);
		check("empty after reset", {7'h0, fifo_empty[0]}, 8'h01);
		$display("Second reset test done");
		tally_and_finish();
	end
endmodule
